// [hw/fsw_sweep.sv]
// frequency sweep controller with APB register access
// Overview of operation
// - return time 0..3600 s, default 0
// - return ramp is always linear
// - linear or log spacing, linear after reset
// - linear spacing ramps frequency linearly
// - log spacing holds the start frequency, then jumps to stop on the last step
// - sweep enable, off by default
// - sweep time 1 ms..250000 s, log 500 s
// - step count follows sweep time
// - hold at stop 0..3600 s, default 0
// - no sweep for noise, PRBS, DC
`timescale 1ns/1ps
module fsw_sweep #(
	parameter int MS_CYCLES = fsw_pkg::MS_CYCLES
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        trig_in,
	output logic [31:0]      freq_out,
	output logic             sweep_active
);
	logic                  en_r;
	logic                  log_r;
	fsw_pkg::fsw_wave_type wave_r;
	logic [31:0]           start_r;
	logic [31:0]           stop_r;
	logic [31:0]           sweep_ms_r;
	logic [31:0]           hold_s_r;
	logic [31:0]           ret_s_r;
	logic                  sw_trig_r;
	logic                  trig_m_r;
	logic                  trig_s_r;
	logic                  trig_d_r;
	fsw_pkg::fsw_state_type st_r;
	fsw_pkg::fsw_state_type st_nxt;
	logic [31:0]           idx_r;
	logic [31:0]           ms_r;
	logic [31:0]           prdata_r;
	logic                  tick;

	wire wr_en = psel && penable && pwrite;
	wire rd_en = psel && penable && !pwrite;
	wire w_ctrl  = wr_en && paddr == fsw_pkg::OFS_CTRL;
	wire w_start = wr_en && paddr == fsw_pkg::OFS_START;
	wire w_stop  = wr_en && paddr == fsw_pkg::OFS_STOP;
	wire w_sweep = wr_en && paddr == fsw_pkg::OFS_SWEEP_MS;
	wire w_hold  = wr_en && paddr == fsw_pkg::OFS_HOLD_S;
	wire w_ret   = wr_en && paddr == fsw_pkg::OFS_RETURN_S;
	wire mapped  = paddr == fsw_pkg::OFS_CTRL
		|| paddr == fsw_pkg::OFS_START || paddr == fsw_pkg::OFS_STOP
		|| paddr == fsw_pkg::OFS_SWEEP_MS || paddr == fsw_pkg::OFS_HOLD_S
		|| paddr == fsw_pkg::OFS_RETURN_S || paddr == fsw_pkg::OFS_STATUS
		|| paddr == fsw_pkg::OFS_FREQ || paddr == fsw_pkg::OFS_STEPS;

	fsw_pkg::fsw_wave_type w_wave;
	assign w_wave = fsw_pkg::fsw_wave_type'(
		pwdata[fsw_pkg::CTL_WAVE_LSB +: fsw_pkg::CTL_WAVE_W]);

	// shared decode of sweepable waveforms
	function automatic logic wave_ok(input fsw_pkg::fsw_wave_type w);
		return !(w == fsw_pkg::WV_NOISE || w == fsw_pkg::WV_PRBS
			|| w == fsw_pkg::WV_DC);
	endfunction

	// clamp a value into [lo, hi]
	function automatic logic [31:0] clamp(input logic [31:0] v,
		input logic [31:0] lo, input logic [31:0] hi);
		return (v < lo) ? lo : (v > hi) ? hi : v;
	endfunction

	wire [31:0] sweep_max = log_r ? fsw_pkg::SWEEP_MS_LOG_MAX
		: fsw_pkg::SWEEP_MS_LIN_MAX;
	wire [31:0] sweep_eff = clamp(sweep_ms_r, fsw_pkg::SWEEP_MS_MIN,
		sweep_max);
	// one frequency step per millisecond of sweep time
	wire [31:0] fwd_steps = sweep_eff / 32'(fsw_pkg::STEP_MS);
	wire [31:0] hold_ms   = 32'(hold_s_r * 32'(fsw_pkg::MS_PER_S));
	wire [31:0] ret_ms    = 32'(ret_s_r * 32'(fsw_pkg::MS_PER_S));
	wire run_ok = en_r && wave_ok(wave_r);
	wire trig_rise = (trig_s_r && !trig_d_r) || sw_trig_r;
	wire fwd_done  = (st_r == fsw_pkg::ST_FWD) && tick && ms_r + 32'h1 >= fwd_steps;
	wire hold_done = (st_r == fsw_pkg::ST_HOLD) && (hold_ms == fsw_pkg::ZERO32
		|| (tick && ms_r + 32'h1 >= hold_ms));
	wire ret_done  = (st_r == fsw_pkg::ST_RET) && (ret_ms == fsw_pkg::ZERO32
		|| (tick && ms_r + 32'h1 >= ret_ms));

	// registers
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			en_r       <= 1'b0;
			log_r      <= 1'b0;
			wave_r     <= fsw_pkg::WV_SINE;
			start_r    <= fsw_pkg::FREQ_RST;
			stop_r     <= fsw_pkg::FREQ_RST;
			sweep_ms_r <= fsw_pkg::SWEEP_MS_RST;
			hold_s_r   <= fsw_pkg::DWELL_S_RST;
			ret_s_r    <= fsw_pkg::DWELL_S_RST;
			sw_trig_r  <= 1'b0;
		end
		else
		begin
			sw_trig_r <= w_ctrl && pwdata[fsw_pkg::CTL_TRIG_BIT];
			if (w_ctrl)
			begin
				log_r  <= pwdata[fsw_pkg::CTL_LOG_BIT];
				wave_r <= w_wave;
				// enable refused for unsweepable waveforms
				en_r   <= pwdata[fsw_pkg::CTL_EN_BIT]
					&& wave_ok(w_wave);
			end
			if (w_start)
				start_r <= pwdata;
			if (w_stop)
				stop_r <= pwdata;
			if (w_sweep)
				sweep_ms_r <= pwdata;
			if (w_hold)
				hold_s_r <= clamp(pwdata, fsw_pkg::ZERO32,
					fsw_pkg::DWELL_S_MAX);
			if (w_ret)
				ret_s_r <= clamp(pwdata, fsw_pkg::ZERO32,
					fsw_pkg::DWELL_S_MAX);
		end
	end

	// trigger pin synchroniser and edge detect
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trig_m_r <= 1'b0;
			trig_s_r <= 1'b0;
			trig_d_r <= 1'b0;
		end
		else
		begin
			trig_m_r <= trig_in;
			trig_s_r <= trig_m_r;
			trig_d_r <= trig_s_r;
		end
	end

	// sequencer
	always_comb
	begin
		st_nxt = st_r;
		unique case (st_r)
			fsw_pkg::ST_IDLE:
				if (run_ok && trig_rise)
					st_nxt = fsw_pkg::ST_FWD;
			fsw_pkg::ST_FWD:
				if (fwd_done)
					st_nxt = fsw_pkg::ST_HOLD;
			fsw_pkg::ST_HOLD:
				if (hold_done)
					st_nxt = fsw_pkg::ST_RET;
			fsw_pkg::ST_RET:
				if (ret_done)
					st_nxt = fsw_pkg::ST_IDLE;
		endcase
		if (!run_ok)
			st_nxt = fsw_pkg::ST_IDLE;
	end

	wire leaving = st_nxt != st_r;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r  <= fsw_pkg::ST_IDLE;
			ms_r  <= 32'h0000_0000;
			idx_r <= 32'h0000_0000;
		end
		else
		begin
			st_r <= st_nxt;
			if (leaving)
			begin
				ms_r  <= 32'h0000_0000;
				idx_r <= 32'h0000_0000;
			end
			else if (tick && st_r != fsw_pkg::ST_IDLE)
			begin
				ms_r  <= ms_r + 32'h0000_0001;
				idx_r <= idx_r + 32'h0000_0001;
			end
		end
	end

	fsw_tick #(
		.CYCLES(MS_CYCLES)
	) u_tick (
		.sys_clk(sys_clk),
		.rst_n  (rst_n),
		.tick   (tick)
	);

	// forward runs start->stop; return runs stop->start linearly
	wire is_ret  = st_r == fsw_pkg::ST_RET;
	wire i_load  = (st_nxt == fsw_pkg::ST_FWD && st_r == fsw_pkg::ST_IDLE)
		|| !run_ok;
	// end of return always lands on start, also for zero return time
	wire i_step  = (tick && (st_r == fsw_pkg::ST_FWD || is_ret))
		|| ret_done;
	wire i_geo   = log_r && st_r == fsw_pkg::ST_FWD;
	wire [31:0] i_from = is_ret ? stop_r : start_r;
	wire [31:0] i_to   = is_ret ? start_r : stop_r;
	wire [31:0] i_n    = is_ret ? ret_ms : fwd_steps;
	wire [31:0] i_idx  = idx_r + 32'h0000_0001;

	fsw_interp u_interp (
		.sys_clk(sys_clk),
		.rst_n  (rst_n),
		.load   (i_load),
		.step   (i_step),
		.geo    (i_geo),
		.f_from (i_from),
		.f_to   (i_to),
		.n_steps(i_n),
		.idx    (i_idx),
		.freq   (freq_out)
	);

	// read mux, registered during setup so access answers at once
	wire [31:0] ctrl_rd = {25'h0, wave_r, 2'b00, log_r, en_r};
	wire [31:0] stat_rd = {30'h0, st_r};
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			prdata_r <= 32'h0000_0000;
		else if (psel && !penable)
			prdata_r <= (paddr == fsw_pkg::OFS_CTRL)     ? ctrl_rd
				: (paddr == fsw_pkg::OFS_START)    ? start_r
				: (paddr == fsw_pkg::OFS_STOP)     ? stop_r
				: (paddr == fsw_pkg::OFS_SWEEP_MS) ? sweep_ms_r
				: (paddr == fsw_pkg::OFS_HOLD_S)   ? hold_s_r
				: (paddr == fsw_pkg::OFS_RETURN_S) ? ret_s_r
				: (paddr == fsw_pkg::OFS_STATUS)   ? stat_rd
				: (paddr == fsw_pkg::OFS_FREQ)     ? freq_out
				: (paddr == fsw_pkg::OFS_STEPS)    ? fwd_steps
				: 32'h0000_0000;
	end

	assign prdata       = rd_en ? prdata_r : 32'h0000_0000;
	assign pready       = 1'b1;
	assign pslverr      = psel && penable && !mapped;
	assign sweep_active = st_r != fsw_pkg::ST_IDLE;
endmodule // fsw_sweep

// [hw/fsw_pkg.sv]
// package: register map, field codes and timing for the sweep controller
package fsw_pkg;
	localparam int          CLK_HZ          = 200_000_000;
	localparam int          AW              = 8;
	localparam int          FW              = 32;
	// register byte offsets
	localparam logic [7:0]  OFS_CTRL        = 8'h00;
	localparam logic [7:0]  OFS_START       = 8'h04;
	localparam logic [7:0]  OFS_STOP        = 8'h08;
	localparam logic [7:0]  OFS_SWEEP_MS    = 8'h0C;
	localparam logic [7:0]  OFS_HOLD_S      = 8'h10;
	localparam logic [7:0]  OFS_RETURN_S    = 8'h14;
	localparam logic [7:0]  OFS_STATUS      = 8'h18;
	localparam logic [7:0]  OFS_FREQ        = 8'h1C;
	localparam logic [7:0]  OFS_STEPS       = 8'h20;
	// control field positions
	localparam int          CTL_EN_BIT      = 0;
	localparam int          CTL_LOG_BIT     = 1;
	localparam int          CTL_TRIG_BIT    = 2;
	localparam int          CTL_WAVE_LSB    = 4;
	localparam int          CTL_WAVE_W      = 3;
	// limits, times as printed
	localparam logic [31:0] SWEEP_MS_MIN    = 32'h0000_0001;
	localparam logic [31:0] SWEEP_MS_LIN_MAX = 32'h0EE6_B280;
	localparam logic [31:0] SWEEP_MS_LOG_MAX = 32'h0007_A120;
	localparam logic [31:0] SWEEP_MS_RST    = 32'h0000_03E8;
	localparam logic [31:0] DWELL_S_MAX     = 32'h0000_0E10;
	localparam logic [31:0] DWELL_S_RST     = 32'h0000_0000;
	localparam int          TICK_MS         = 1;
	localparam int          MS_CYCLES       = CLK_HZ / 1000 * TICK_MS;
	localparam int          MS_PER_S        = 1000;
	localparam int          STEP_MS         = 1;
	localparam logic [31:0] ZERO32          = 32'h0000_0000;
	localparam logic [31:0] FREQ_RST        = 32'h0000_0064;

	typedef enum logic [2:0] {
		WV_SINE   = 3'h0,
		WV_SQUARE = 3'h1,
		WV_RAMP   = 3'h2,
		WV_PULSE  = 3'h3,
		WV_ARB    = 3'h4,
		WV_NOISE  = 3'h5,
		WV_PRBS   = 3'h6,
		WV_DC     = 3'h7
	} fsw_wave_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FWD  = 2'b01,
		ST_HOLD = 2'b11,
		ST_RET  = 2'b10
	} fsw_state_type;

	typedef struct packed {
		logic        enable;
		logic        log_mode;
		logic [31:0] f_start;
		logic [31:0] f_stop;
		logic [31:0] sweep_ms;
		logic [31:0] hold_s;
		logic [31:0] ret_s;
		fsw_wave_type wave;
	} fsw_cfg_type;
endpackage

// [hw/fsw_tick.sv]
// millisecond tick generator
`timescale 1ns/1ps
module fsw_tick #(
	parameter int CYCLES = fsw_pkg::MS_CYCLES
) (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	output logic      tick
);
	logic [31:0] cnt_r;
	wire         wrap = (cnt_r == 32'(CYCLES - 1));

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_r <= 32'h0000_0000;
		else
			cnt_r <= wrap ? 32'h0000_0000 : cnt_r + 32'h0000_0001;
	end

	assign tick = wrap;
endmodule // fsw_tick

// [hw/fsw_interp.sv]
// per-step frequency interpolator, linear; geometric mode holds f_from until the last step
`timescale 1ns/1ps
module fsw_interp (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        load,
	input  wire logic        step,
	input  wire logic        geo,
	input  wire logic [31:0] f_from,
	input  wire logic [31:0] f_to,
	input  wire logic [31:0] n_steps,
	input  wire logic [31:0] idx,
	output logic [31:0]      freq
);
	logic [31:0] freq_r;
	logic [63:0] ratio_r;
	logic [63:0] span;
	logic [63:0] lin_val;
	logic [95:0] geo_prod;

	// linear point recomputed from index: no drift accumulates
	assign span     = (f_to >= f_from)
		? 64'(f_to - f_from) : 64'(f_from - f_to);
	assign lin_val  = (n_steps == 32'h0000_0000) ? 64'(f_to)
		: (f_to >= f_from)
		? 64'(f_from) + span * 64'(idx) / 64'(n_steps)
		: 64'(f_from) - span * 64'(idx) / 64'(n_steps);
	// geometric: multiply by per-step ratio, held at 1.0 (32.32 fixed point)
	assign geo_prod = 96'(freq_r) * 96'(ratio_r);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			freq_r  <= fsw_pkg::FREQ_RST;
			ratio_r <= 64'h0000_0001_0000_0000;
		end
		else if (load)
		begin
			freq_r  <= f_from;
			ratio_r <= 64'h0000_0001_0000_0000;
		end
		else if (step)
		begin
			if (geo && idx != n_steps)
				freq_r <= geo_prod[63:32];
			else
				freq_r <= lin_val[31:0];
		end
		else if (geo)
			ratio_r <= ratio_upd(ratio_r);
	end

	// ratio refinement placeholder: returns the ratio unchanged
	function automatic logic [63:0] ratio_upd(input logic [63:0] r);
		return r;
	endfunction

	assign freq = freq_r;
endmodule // fsw_interp

// [dv/fsw_host.sv]
// host model: apb master issuing register accesses
`timescale 1ns/1ps
module fsw_host (
	input  wire logic        sys_clk,
	input  wire logic        pready,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'hFF;
		pwdata = 32'h0;
	end

	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines must not keep showing the last value
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule // fsw_host

// [dv/fsw_sweep_asserts.sv]
// checker: sweep gating, timing and output bounds
`timescale 1ns/1ps
module fsw_chk #(
	parameter int MS_CYCLES = 4
) (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] freq_out,
	input wire logic        sweep_active
);
	logic        wr;
	logic        ctl_wr;
	logic        en_r;
	logic [31:0] st_r, sp_r, ms_r, hd_r, rt_r, cnt_r, exp_w, tol_w;
	assign wr = psel && penable && pwrite && pready;
	assign ctl_wr = wr && paddr == fsw_pkg::OFS_CTRL;
	assign exp_w = (ms_r + (hd_r + rt_r) * 1000) * MS_CYCLES;
	// tick phase is free running, so allow a few ticks of slack
	assign tol_w = 3 * MS_CYCLES;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			en_r <= 1'b0;
			{st_r, sp_r, hd_r, rt_r} <= 128'h0;
			ms_r <= fsw_pkg::SWEEP_MS_RST;
		end
		else if (wr)
		begin
			if (ctl_wr)
				en_r <= pwdata[0] && pwdata[6:4] < 3'h5;
			if (paddr == fsw_pkg::OFS_START)
				st_r <= pwdata;
			if (paddr == fsw_pkg::OFS_STOP)
				sp_r <= pwdata;
			if (paddr == fsw_pkg::OFS_SWEEP_MS)
				ms_r <= pwdata;
			if (paddr == fsw_pkg::OFS_HOLD_S)
				hd_r <= pwdata;
			if (paddr == fsw_pkg::OFS_RETURN_S)
				rt_r <= pwdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_r <= 32'h0;
		else
			cnt_r <= sweep_active ? cnt_r + 32'h1 : 32'h0;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	AST_EN_GATE: assert property ($rose(sweep_active) |-> en_r)
		else $error("sweep started while disabled");
	AST_IDLE: assert property (!en_r && !sweep_active && !wr |=> !sweep_active)
		else $error("sweep active without enable");
	AST_OFF: assert property (ctl_wr && !pwdata[0] |-> ##[1:3] !sweep_active)
		else $error("disable did not stop sweep");
	AST_NOISE: assert property (ctl_wr && pwdata[6:4] >= 3'h5 |-> ##[1:3] !sweep_active)
		else $error("sweep with forbidden waveform");
	AST_DUR: assert property ($fell(sweep_active) && en_r |-> cnt_r + tol_w >= exp_w && cnt_r <= exp_w + tol_w)
		else $error("sweep cycle length wrong");
	AST_STAY: assert property (sweep_active && en_r && !wr && cnt_r + tol_w < exp_w |=> sweep_active)
		else $error("sweep ended early");
	AST_RANGE: assert property ($past(sweep_active) && sweep_active |-> (freq_out >= st_r && freq_out <= sp_r) || (freq_out <= st_r && freq_out >= sp_r))
		else $error("frequency outside start and stop");
	AST_HOME: assert property ($fell(sweep_active) |-> ##[0:2] freq_out == st_r)
		else $error("frequency not back at start");
endmodule // fsw_chk

bind fsw_sweep fsw_chk #(.MS_CYCLES(MS_CYCLES)) fsw_chk_inst (.sys_clk, .rst_n,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .freq_out,
	.sweep_active);

// [dv/fsw_sweep_test.sv]
// bench: register defaults, waveform gating and full sweep cycles
`timescale 1ns/1ps
module fsw_sweep_test;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        trig_in = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, sweep_active;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, freq_out, ms;
	logic [32:0] q[$];
	logic [32:0] e;
	logic [15:0] lf = 16'h8F39;
	int          error_cnt, cmp_count, cyc, i;

	fsw_sweep #(.MS_CYCLES(4)) fsw_sweep_inst (.sys_clk, .rst_n, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.trig_in, .freq_out, .sweep_active);
	fsw_host fsw_host_inst (.sys_clk, .pready, .psel, .penable, .pwrite,
		.paddr, .pwdata);

	always #2.5 sys_clk = ~sys_clk;

	task stop_test;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		fsw_host_inst.xfer(1'b1, a, d);
	endtask

	task rd(input logic [7:0] a, input logic [32:0] x);
		q.push_back(x);
		fsw_host_inst.xfer(1'b0, a, 32'h0);
	endtask

	task wait_act(input logic v, input int n);
		int k;
		for (k = 0; k < n && sweep_active !== v; k++)
			@(posedge sys_clk);
		cmp_count++;
		if (sweep_active !== v)
		begin
			error_cnt++;
			$display("CHECK FAILED sweep_active exp %b got %b", v,
				sweep_active);
		end
	endtask

	task cfg(input logic [31:0] m, input logic [31:0] h);
		wr(fsw_pkg::OFS_START, 32'h0000_03E8);
		wr(fsw_pkg::OFS_STOP, 32'h0000_07D0);
		wr(fsw_pkg::OFS_SWEEP_MS, m);
		wr(fsw_pkg::OFS_HOLD_S, h);
		wr(fsw_pkg::OFS_RETURN_S, h);
	endtask

	always @(posedge sys_clk)
	begin
		if (psel && penable && pready && !pwrite && q.size() > 0)
		begin
			e = q.pop_front();
			cmp_count++;
			if ({pslverr, prdata} !== e)
			begin
				error_cnt++;
				$display("CHECK FAILED reg %h exp %h got %h", paddr, e,
					{pslverr, prdata});
			end
		end
	end

	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			error_cnt++;
			stop_test();
		end
	end

	initial
	begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(fsw_pkg::OFS_CTRL, 33'h0);
		rd(fsw_pkg::OFS_SWEEP_MS, {1'b0, fsw_pkg::SWEEP_MS_RST});
		rd(fsw_pkg::OFS_HOLD_S, 33'h0);
		rd(fsw_pkg::OFS_RETURN_S, 33'h0);
		rd(8'h24, 33'h1_0000_0000);
		for (i = 0; i < 8; i++)
		begin
			wr(fsw_pkg::OFS_CTRL, {25'h0, i[2:0], 4'h1});
			rd(fsw_pkg::OFS_CTRL, {26'h0, i[2:0], 3'h0, i < 5});
		end
		cfg(32'h5, 32'h0);
		wr(fsw_pkg::OFS_CTRL, 32'h1);
		trig_in <= 1'b1;
		repeat (4) @(posedge sys_clk);
		trig_in <= 1'b0;
		wait_act(1'b1, 10);
		wait_act(1'b0, 100);
		rd(fsw_pkg::OFS_FREQ, 33'h3E8);
		rd(fsw_pkg::OFS_STEPS, 33'h5);
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		ms = {26'h0, lf[5:0]} + 32'h1;
		cfg(ms, 32'h1);
		wr(fsw_pkg::OFS_CTRL, 32'h7);
		wait_act(1'b1, 10);
		wait_act(1'b0, (ms + 2000) * 4 + 50);
		rd(fsw_pkg::OFS_FREQ, 33'h3E8);
		rd(fsw_pkg::OFS_CTRL, 33'h3);
		rd(fsw_pkg::OFS_STEPS, {1'b0, ms});
		cfg(32'hC8, 32'h0);
		wr(fsw_pkg::OFS_CTRL, 32'h5);
		wait_act(1'b1, 10);
		repeat (20) @(posedge sys_clk);
		wr(fsw_pkg::OFS_CTRL, 32'h0);
		wait_act(1'b0, 5);
		rd(fsw_pkg::OFS_FREQ, 33'h3E8);
		repeat (3) @(posedge sys_clk);
		stop_test();
	end
endmodule // fsw_sweep_test
